// ==== rtl/wdt_csr.sv ====
`timescale 1ns/1ps
// Overview of operation
// - overflow flag sets when counter wraps from FF to 00.
// - in watchdog mode internal reset clears flag after it is set.
// - software clears flag only by read while set, then writing zero.
// - writing one to the flag does nothing.
// - bit 5 written only when bit 6 written 0; bit 6 reads 1.
// - bit 5: 0 watchdog mode, 1 interval timer mode.
// - bit 3 written only when bit 4 written 0; bit 4 reads 1.
// - bit 3 enables overflow interrupts on wrap_irq_o in interval mode; irq_o does not use bit 3.
// - bits 2..0 reserved, ignore writes, read as 1.
// - counter is 8-bit up-counter, software readable and writable.
// - watchdog mode overflow raises internal reset and reset indicator.
module wdt_csr (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  // avalon-mm slave
  input  wire logic [17:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic [1:0]       avs_response_o,
  // system side
  output logic             internal_reset_o,
  output logic             wrap_irq_o,
  output logic             irq_o
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]  count_r;
  logic        wrap_flag_r;
  logic        armed_r;
  logic        mode_r;
  logic        ien_r;
  logic [3:0]  clksel_r;
  logic        reset_ind_r;
  logic        rst_req_r;
  logic        wrap_irq_r;
  logic [1:0]  stat_r;
  logic [1:0]  mask_r;
  logic        irq_r;
  logic        ack_r;
  logic        wait_r;
  logic [31:0] rdata_r;
  logic [1:0]  resp_r;
  tick_if      tk ();

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic [15:0] idx;
  logic        req;
  logic        wr;
  logic        rd;
  logic        lane0;
  logic [7:0]  wd;
  logic        hit_csr;
  logic        hit_cnt;
  logic        hit_clk;
  logic        hit_stat;
  logic        hit_mask;
  logic        hit_any;
  logic        wrap;

  assign idx      = avs_address_i[17:2];
  assign req      = (avs_read_i | avs_write_i) & ~ack_r;
  assign wr       = req & avs_write_i;
  assign rd       = req & avs_read_i;
  assign lane0    = avs_byteenable_i[0];
  assign wd       = avs_writedata_i[7:0];
  assign hit_csr  = (idx == wdt_pkg::CSR2_INDEX);
  assign hit_cnt  = (idx == wdt_pkg::COUNTER_INDEX);
  assign hit_clk  = (idx == wdt_pkg::CLKSEL_INDEX);
  assign hit_stat = (idx == wdt_pkg::IRQ_STAT_INDEX);
  assign hit_mask = (idx == wdt_pkg::IRQ_MASK_INDEX);
  assign hit_any  = hit_csr | hit_cnt | hit_clk | hit_stat | hit_mask;

  // one wait state: answer in the cycle after the request is seen
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  // registered copy of waitrequest so the pin comes straight from a flop
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= ~req;
    end
  end

  // ---------------------------------------------------------------
  // timer counter and tick source
  // ---------------------------------------------------------------
  assign tk.sel = clksel_r;
  wdt_prescaler u_presc (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .tk        (tk)
  );

  assign wrap = tk.tick & (count_r == wdt_pkg::COUNTER_MAX);

  // software write wins over a tick in the same cycle
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_r <= wdt_pkg::COUNTER_RESET;
    end else if (wr && hit_cnt && lane0) begin
      count_r <= wd;
    end else if (tk.tick) begin
      count_r <= count_r + 8'h01;
    end
  end

  // clock select, upper bits read as one
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clksel_r <= wdt_pkg::CLKSEL_RESET;
    end else if (wr && hit_clk && lane0) begin
      clksel_r <= wd[3:0];
    end
  end

  // ---------------------------------------------------------------
  // control/status register 2
  // ---------------------------------------------------------------
  // guarded mode bit
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_r <= wdt_pkg::MODE_RESET;
    end else if (wr && hit_csr && lane0 && !wd[wdt_pkg::MODE_GUARD_BIT]) begin
      mode_r <= wd[wdt_pkg::MODE_BIT];
    end
  end

  // guarded interrupt enable
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ien_r <= wdt_pkg::IEN_RESET;
    end else if (wr && hit_csr && lane0 && !wd[wdt_pkg::IEN_GUARD_BIT]) begin
      ien_r <= wd[wdt_pkg::IEN_BIT];
    end
  end

  // arm the clear on a read that sees the flag set; any later csr write disarms
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      armed_r <= 1'b0;
    end else if (rd && hit_csr && wrap_flag_r) begin
      armed_r <= 1'b1;
    end else if ((wr && hit_csr) || !wrap_flag_r) begin
      armed_r <= 1'b0;
    end
  end

  // wrap sets beat any clear in the same cycle
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wrap_flag_r <= 1'b0;
    end else if (wrap) begin
      wrap_flag_r <= 1'b1;
    end else if (rst_req_r) begin
      wrap_flag_r <= 1'b0;
    end else if (wr && hit_csr && lane0 && armed_r && !wd[wdt_pkg::WRAP_FLAG_BIT]) begin
      wrap_flag_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // watchdog reset path
  // ---------------------------------------------------------------
  // one-cycle internal reset pulse in watchdog mode
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_req_r <= 1'b0;
    end else begin
      rst_req_r <= wrap & ~mode_r;
    end
  end

  // indicator survives the internal reset; the pin or a write of one to status bit 1 clears it
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reset_ind_r <= 1'b0;
    end else if (wrap && !mode_r) begin
      reset_ind_r <= 1'b1;
    end else if (wr && hit_stat && lane0 && wd[wdt_pkg::STAT_RESET_BIT]) begin
      reset_ind_r <= 1'b0;
    end
  end

  // level request toward the interrupt controller
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wrap_irq_r <= 1'b0;
    end else begin
      wrap_irq_r <= wrap_flag_r & mode_r & ien_r;
    end
  end

  // ---------------------------------------------------------------
  // sticky status, mask, interrupt line
  // ---------------------------------------------------------------
  logic [1:0] ev;
  logic [1:0] w1c;
  assign ev  = {wrap & ~mode_r, wrap};
  assign w1c = (wr && hit_stat && lane0) ? wd[1:0] : 2'b00;

  // set wins over a write-one clear
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stat_r <= 2'b00;
    end else begin
      stat_r <= ev | (stat_r & ~w1c);
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask_r <= 2'b00;
    end else if (wr && hit_mask && lane0) begin
      mask_r <= wd[1:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(stat_r & mask_r);
    end
  end

  // ---------------------------------------------------------------
  // read data and response
  // ---------------------------------------------------------------
  logic [7:0] csr_view;
  always_comb begin
    csr_view = wdt_pkg::CSR2_ONES_MASK;
    csr_view[wdt_pkg::WRAP_FLAG_BIT] = wrap_flag_r;
    csr_view[wdt_pkg::MODE_BIT]      = mode_r;
    csr_view[wdt_pkg::IEN_BIT]       = ien_r;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_r <= 32'h0000_0000;
      resp_r  <= 2'b00;
    end else if (req) begin
      resp_r  <= hit_any ? 2'b00 : 2'b11;
      rdata_r <= 32'h0000_0000;
      if (rd) begin
        if (hit_csr) begin
          rdata_r[7:0] <= csr_view;
        end else if (hit_cnt) begin
          rdata_r[7:0] <= count_r;
        end else if (hit_clk) begin
          rdata_r[7:0] <= wdt_pkg::CLKSEL_ONES | {4'h0, clksel_r};
        end else if (hit_stat) begin
          rdata_r[7:0] <= {6'h00, stat_r[1] | reset_ind_r, stat_r[0]};
        end else if (hit_mask) begin
          rdata_r[7:0] <= {6'h00, mask_r};
        end
      end
    end
  end

  // waitrequest high except in the answer cycle
  assign avs_waitrequest_o = wait_r;
  assign avs_readdata_o    = rdata_r;
  assign avs_response_o    = resp_r;
  assign internal_reset_o  = rst_req_r;
  assign wrap_irq_o        = wrap_irq_r;
  assign irq_o             = irq_r;
endmodule : wdt_csr

// ==== rtl/wdt_pkg.sv ====
package wdt_pkg;
  // ---------------------------------------------------------------
  // register map (word index times four gives byte address)
  // ---------------------------------------------------------------
  localparam logic [15:0] CSR2_INDEX    = 16'hFFB2;
  localparam logic [15:0] COUNTER_INDEX = 16'hFFB0;
  localparam logic [15:0] CLKSEL_INDEX  = 16'hFFB3;
  localparam logic [15:0] IRQ_STAT_INDEX = 16'hFFB4;
  localparam logic [15:0] IRQ_MASK_INDEX = 16'hFFB5;
  localparam int          ADDR_W        = 18;
  // ---------------------------------------------------------------
  // field positions of watchdog_control_status_2
  // ---------------------------------------------------------------
  localparam int WRAP_FLAG_BIT   = 7;
  localparam int MODE_GUARD_BIT  = 6;
  localparam int MODE_BIT        = 5;
  localparam int IEN_GUARD_BIT   = 4;
  localparam int IEN_BIT         = 3;
  localparam logic [7:0] CSR2_ONES_MASK = 8'h57;
  // ---------------------------------------------------------------
  // reset values and constants
  // ---------------------------------------------------------------
  localparam logic        MODE_RESET     = 1'b1;
  localparam logic        IEN_RESET      = 1'b0;
  localparam logic [7:0]  COUNTER_RESET  = 8'h00;
  localparam logic [7:0]  COUNTER_MAX    = 8'hFF;
  localparam logic [3:0]  CLKSEL_RESET   = 4'hF;
  localparam logic [7:0]  CLKSEL_ONES    = 8'hF0;
  localparam int          CLKSEL_OSC_BIT = 3;
  localparam int          OSC_DIV_LOG2   = 11;
  localparam int          PRESC_W        = 13;
  // irq status bits
  localparam int STAT_WRAP_BIT  = 0;
  localparam int STAT_RESET_BIT = 1;
endpackage : wdt_pkg

// ==== rtl/tick_if.sv ====
`timescale 1ns/1ps
interface tick_if;
  logic       tick;   // one-cycle count enable
  logic [3:0] sel;    // clock select field
  modport src (output tick, input sel);
  modport dst (input tick, output sel);
endinterface : tick_if

// ==== rtl/wdt_prescaler.sv ====
`timescale 1ns/1ps
module wdt_prescaler (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  // tick to counter
  tick_if.src       tk
);
  logic [wdt_pkg::PRESC_W-1:0] div_r;
  logic [wdt_pkg::PRESC_W-1:0] div_nxt;
  logic                        tick_r;
  logic [3:0]                  tap;

  // free-running divider; a change of select may cut one period short
  assign div_nxt = div_r + {{(wdt_pkg::PRESC_W-1){1'b0}}, 1'b1};
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  // select bit 3 set: bits 2..0 pick 64..8192; bit 3 clear: oscillator stand-in uses 2048
  always_comb begin
    tap = 4'h0;
    if (tk.sel[wdt_pkg::CLKSEL_OSC_BIT]) begin
      tap = {1'b0, tk.sel[2:0]} + 4'h5;
    end else begin
      tap = 4'(wdt_pkg::OSC_DIV_LOG2 - 1);
    end
  end

  // one pulse when the chosen tap rolls over
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= div_r[tap] & ~div_nxt[tap];
    end
  end

  assign tk.tick = tick_r;
endmodule : wdt_prescaler

// ==== verification/wdt_csr_checker.sv ====
`timescale 1ns/1ps
module wdt_csr_checker (
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        nrst_i,
  // avalon-mm slave
  input wire logic [17:0] avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [1:0]  avs_response_o,
  // system side
  input wire logic        internal_reset_o,
  input wire logic        wrap_irq_o,
  input wire logic        irq_o
);
  // ------------------------------------------------------------
  // address decode and sequences
  // ------------------------------------------------------------
  logic [15:0] idx;
  logic        mapped;
  logic        ack;
  assign idx    = avs_address_i[17:2];
  assign mapped = idx inside {wdt_pkg::CSR2_INDEX, wdt_pkg::COUNTER_INDEX,
                  wdt_pkg::CLKSEL_INDEX, wdt_pkg::IRQ_STAT_INDEX, wdt_pkg::IRQ_MASK_INDEX};
  assign ack    = !avs_waitrequest_o;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_req; (avs_read_i || avs_write_i) && avs_waitrequest_o; endsequence
  sequence s_ack; !avs_waitrequest_o ##1 avs_waitrequest_o; endsequence
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_one_wait; s_req |=> s_ack; endproperty
  property p_idle; !(avs_read_i || avs_write_i) && avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  property p_upper_zero; ack && avs_read_i |-> avs_readdata_o[31:8] == 24'h000000; endproperty
  property p_resp; ack |-> avs_response_o == (mapped ? 2'b00 : 2'b11); endproperty
  property p_unmapped_rd; ack && avs_read_i && !mapped |-> avs_readdata_o == 32'h00000000;
  endproperty
  property p_csr2_ones;
    ack && avs_read_i && idx == wdt_pkg::CSR2_INDEX |->
      (avs_readdata_o[7:0] & wdt_pkg::CSR2_ONES_MASK) == wdt_pkg::CSR2_ONES_MASK;
  endproperty
  property p_rst_pulse; internal_reset_o |=> !internal_reset_o; endproperty
  property p_modes_excl; !(internal_reset_o && wrap_irq_o); endproperty
  a_one_wait: assert property (p_one_wait) else $error("access not answered in one cycle");
  a_idle: assert property (p_idle) else $error("waitrequest dropped with no request");
  a_upper_zero: assert property (p_upper_zero) else $error("read data upper bytes not zero");
  a_resp: assert property (p_resp) else $error("wrong response code");
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
  a_csr2_ones: assert property (p_csr2_ones) else $error("csr2 fixed bits not one");
  a_rst_pulse: assert property (p_rst_pulse) else $error("internal reset longer than a cycle");
  a_modes_excl: assert property (p_modes_excl) else $error("reset and irq in one mode");
endmodule : wdt_csr_checker

bind wdt_csr wdt_csr_checker chk (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .avs_response_o(avs_response_o), .internal_reset_o(internal_reset_o),
  .wrap_irq_o(wrap_irq_o), .irq_o(irq_o));

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  // ------------------------------------------------------------
  // bench signals
  // ------------------------------------------------------------
  logic        sys_clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [17:0] avs_address_i = 18'h00000;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [1:0]  avs_response_o;
  logic        internal_reset_o, wrap_irq_o, irq_o;
  int          fails = 0;
  int          n_compared = 0;
  int          n_rst = 0;
  logic [7:0]  q;
  logic [1:0]  rsp;
  localparam logic [17:0] CSR2 = {wdt_pkg::CSR2_INDEX, 2'b00};
  localparam logic [17:0] CNT  = {wdt_pkg::COUNTER_INDEX, 2'b00};
  localparam logic [17:0] CSEL = {wdt_pkg::CLKSEL_INDEX, 2'b00};
  localparam logic [17:0] STAT = {wdt_pkg::IRQ_STAT_INDEX, 2'b00};
  localparam logic [17:0] MASK = {wdt_pkg::IRQ_MASK_INDEX, 2'b00};

  wdt_csr dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
    .internal_reset_o(internal_reset_o), .wrap_irq_o(wrap_irq_o), .irq_o(irq_o));

  // 10 MHz clock, reset pulses counted as they pass
  initial begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    if (internal_reset_o === 1'b1) n_rst++;
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic test_done;
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  // one avalon access; holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [17:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= {24'h000000, d};
    avs_read_i      <= !wr;
    avs_write_i     <= wr;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) begin
      fails++;
      test_done();
    end
    q   = avs_readdata_o[7:0];
    rsp = avs_response_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus

  task automatic rd_chk(input string name, input logic [17:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check(name, {24'h0, q}, {24'h0, exp});
  endtask : rd_chk

  // bounded poll until a bit of a register reads one
  task automatic poll(input logic [17:0] a, input int b);
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 8'h00);
      n++;
    end while (q[b] !== 1'b1 && n < 300);
    if (n >= 300) begin
      fails++;
      test_done();
    end
  endtask : poll

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_and_map;
    rd_chk("csr2 reset", CSR2, 8'h77);
    rd_chk("clksel reset", CSEL, 8'hFF);
    bus(1'b1, CNT, 8'h5A);
    rd_chk("counter rw", CNT, 8'h5A);
    bus(1'b0, 18'h00000, 8'h00);
    check("unmapped resp", {30'h0, rsp}, {30'h0, 2'b11});
  endtask : t_reset_and_map

  task automatic t_guards;
    bus(1'b1, CSR2, 8'h58);
    rd_chk("guarded write", CSR2, 8'h77);
    bus(1'b1, CSR2, 8'h08);
    rd_chk("unguarded write", CSR2, 8'h5F);
    bus(1'b1, CSR2, 8'h20);
    rd_chk("interval mode", CSR2, 8'h77);
  endtask : t_guards

  task automatic t_interval_wrap;
    bus(1'b1, CSEL, 8'h08);
    bus(1'b1, CNT, 8'hFF);
    poll(CSR2, 7);
    bus(1'b1, CSR2, 8'hA0);
    repeat (2) @(posedge sys_clk_i);
    check("irq with enable off", wrap_irq_o, 1'b0);
    bus(1'b1, CSR2, 8'h28);
    repeat (2) @(posedge sys_clk_i);
    check("irq with enable on", wrap_irq_o, 1'b1);
    bus(1'b1, CSEL, 8'h00);
    rd_chk("write zero unread", CSR2, 8'hFF);
    bus(1'b1, CSR2, 8'h28);
    rd_chk("read then write zero", CSR2, 8'h7F);
    repeat (2) @(posedge sys_clk_i);
    check("irq after clear", wrap_irq_o, 1'b0);
    check("no watchdog reset", n_rst, 0);
    bus(1'b1, MASK, 8'h01);
    repeat (2) @(posedge sys_clk_i);
    check("irq unmasked", irq_o, 1'b1);
    bus(1'b1, STAT, 8'h01);
    repeat (2) @(posedge sys_clk_i);
    check("irq after w1c", irq_o, 1'b0);
  endtask : t_interval_wrap

  task automatic t_watchdog_wrap;
    bus(1'b1, CSEL, 8'h08);
    bus(1'b1, CSR2, 8'h00);
    bus(1'b1, CNT, 8'hFF);
    poll(STAT, 1);
    check("reset pulses", n_rst, 1);
    rd_chk("flag auto cleared", CSR2, 8'h57);
    check("no irq in watchdog", wrap_irq_o, 1'b0);
    bus(1'b1, STAT, 8'h03);
    rd_chk("status cleared", STAT, 8'h00);
  endtask : t_watchdog_wrap

  // ------------------------------------------------------------
  // main sequence and hang guard
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    t_reset_and_map();
    t_guards();
    t_interval_wrap();
    t_watchdog_wrap();
    test_done();
  end
  initial begin
    repeat (90000) @(posedge sys_clk_i);
    fails++;
    test_done();
  end
endmodule : tb_top
